// ==== logic/fpprc_port_ctrl.sv ====
// Port control slice: parity check and generation, reset sequencing, direction.
// Assumes port clocks, reset and strobes are levels synchronous to hclk;
// FIFO array, flag synchronisers and mailbox registers sit outside.
//
// The address map and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module fpprc_port_ctrl
  import fpprc_pkg::*;
(
  // System clock and bus reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  // Device pins, shared
  input wire logic dev_rst_n,
  input wire logic odd_even,
  input wire logic offset_sel_lo,
  input wire logic offset_sel_hi,
  // Port A pins
  input wire logic porta_clk,
  input wire logic porta_select_n,
  input wire logic porta_en,
  input wire logic porta_dir,
  input wire logic porta_mailbox_sel,
  input wire logic porta_parity_gen_en,
  input wire logic [WORD_W-1:0] porta_din,
  output logic [WORD_W-1:0] porta_dout,
  output logic porta_oe,
  output logic porta_parity_error_n,
  // Port B pins
  input wire logic portb_clk,
  input wire logic portb_select_n,
  input wire logic portb_en,
  input wire logic portb_dir,
  input wire logic portb_mailbox_sel,
  input wire logic portb_parity_gen_en,
  input wire logic [WORD_W-1:0] portb_din,
  output logic [WORD_W-1:0] portb_dout,
  output logic portb_oe,
  output logic portb_parity_error_n,
  // Core side: flags from the synchronisers
  input wire logic almost_full_in_n,
  input wire logic almost_empty_in_n,
  input wire logic empty_in_n,
  input wire logic full_in_n,
  input wire logic mail1_full_in_n,
  input wire logic mail2_full_in_n,
  // Core side: read data sources
  input wire logic [WORD_W-1:0] fifo_rdata,
  input wire logic [WORD_W-1:0] mail1_rdata,
  input wire logic [WORD_W-1:0] mail2_rdata,
  // Core side: transfer strobes and offset choice
  output logic porta_wr,
  output logic porta_rd,
  output logic portb_wr,
  output logic portb_rd,
  output logic [1:0] flag_offset_sel,
  output logic dev_in_reset,
  // Flag pins
  output logic almost_full_n,
  output logic almost_empty_n,
  output logic empty_n,
  output logic full_n,
  output logic mail1_full_n,
  output logic mail2_full_n
);
  // Port clock edge detection
  logic porta_clk_q, portb_clk_q; // Last sampled clock levels
  logic dev_rst_q; // Last sampled reset pin
  wire logic a_rise = porta_clk & ~porta_clk_q;
  wire logic b_rise = portb_clk & ~portb_clk_q;
  wire logic rst_rise = dev_rst_n & ~dev_rst_q;

  // Reset sequencer
  fpprc_rst_t rst_state_q; // Device held in reset or running
  logic [2:0] a_cnt_q, b_cnt_q; // Port clock edges seen during reset
  logic [1:0] offset_q; // Latched offset selects
  logic ctrl_ports_q; // Software gate on port transfers

  // Parity trees
  logic a_fail, b_fail; // Any byte bad on the pins
  logic [WORD_W-1:0] a_gen, b_gen; // Data with generated parity

  // Bus and interrupt state
  logic [IRQ_W-1:0] istat_q, imask_q;
  logic wr_pend_q; // Write data phase pending
  logic [3:0] wr_ofs_q; // Offset of pending write
  logic [WORD_W-1:0] porta_dout_q, portb_dout_q;
  logic [31:0] hrdata_q;
  logic pea_q, peb_q; // Last flag levels, for fall events
  logic done_evt; // Reset sequence finished this cycle

  // Port A and port B trees share the polarity pin
  fpprc_parity_tree u_tree_a (
    .data(porta_dout_q),
    .odd(odd_even),
    .fail_any(),
    .gen_word(a_gen)
  );
  fpprc_parity_tree u_tree_b (
    .data(portb_dout_q),
    .odd(odd_even),
    .fail_any(),
    .gen_word(b_gen)
  );
  fpprc_parity_tree u_chk_a (
    .data(porta_din),
    .odd(odd_even),
    .fail_any(a_fail),
    .gen_word()
  );
  fpprc_parity_tree u_chk_b (
    .data(portb_din),
    .odd(odd_even),
    .fail_any(b_fail),
    .gen_word()
  );

  // Transfer qualification
  wire logic running = (rst_state_q == FPPRC_RUN) & dev_rst_n;
  wire logic a_act = ~porta_select_n & porta_en; // R17
  wire logic b_act = ~portb_select_n & portb_en; // R17
  wire logic a_go = a_rise & a_act & running & ctrl_ports_q;
  wire logic b_go = b_rise & b_act & running & ctrl_ports_q;
  // Mailbox reads with generation set up
  wire logic a_m2_gen = a_act & ~porta_dir & porta_mailbox_sel & porta_parity_gen_en;
  wire logic b_m1_gen = b_act & ~portb_dir & portb_mailbox_sel & portb_parity_gen_en;
  // Port B source: mail1 when mailbox selected, FIFO otherwise
  wire logic [WORD_W-1:0] portb_sel_data = portb_mailbox_sel ? mail1_rdata : fifo_rdata;
  wire logic [WORD_W-1:0] porta_sel_data = porta_mailbox_sel ? mail2_rdata : '0;

  // Strobes to the core, one hclk per enabled port clock edge
  assign porta_wr = a_go & porta_dir; // R11
  assign porta_rd = a_go & ~porta_dir; // R11
  assign portb_wr = b_go & portb_dir; // R13
  assign portb_rd = b_go & ~portb_dir; // R13

  // Output enables; drive only while reading
  assign porta_oe = ~porta_select_n & ~porta_dir; // R12
  assign portb_oe = ~portb_select_n & ~portb_dir; // R14

  // Error flags: combinational, forced high during mailbox reads with generation
  assign porta_parity_error_n = a_m2_gen | ~a_fail; // R16 R18
  assign portb_parity_error_n = b_m1_gen | ~b_fail; // R01 R04 R18

  // Generated parity applied to the driven word while enabled; port A also needs its mailbox selected
  assign porta_dout = porta_parity_gen_en & porta_mailbox_sel ? a_gen : porta_dout_q; // R05
  assign portb_dout = portb_parity_gen_en ? b_gen : portb_dout_q; // R06

  // Flag pins take reset defaults while the device is in reset
  assign dev_in_reset = ~running;
  assign almost_full_n = running ? almost_full_in_n : 1'b1; // R09
  assign mail1_full_n = running ? mail1_full_in_n : 1'b1; // R09
  assign mail2_full_n = running ? mail2_full_in_n : 1'b1; // R09
  assign almost_empty_n = running & almost_empty_in_n; // R09
  assign empty_n = running & empty_in_n; // R09
  assign full_n = running & full_in_n; // R09
  assign flag_offset_sel = offset_q;

  // Edge detectors
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      // Start high so a pin that is already high never looks like a rise
      porta_clk_q <= 1'b1;
      portb_clk_q <= 1'b1;
      dev_rst_q <= 1'b1;
    end
    else
    begin
      porta_clk_q <= porta_clk;
      portb_clk_q <= portb_clk;
      dev_rst_q <= dev_rst_n;
    end
  end

  // Reset edge counters; saturate at the needed count
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      a_cnt_q <= '0;
      b_cnt_q <= '0;
    end
    else if (dev_rst_n)
    begin
      // Counts restart with every new reset pulse
      a_cnt_q <= '0;
      b_cnt_q <= '0;
    end
    else
    begin
      if (a_rise && a_cnt_q != RST_EDGES)
        a_cnt_q <= a_cnt_q + 3'h1; // R08
      if (b_rise && b_cnt_q != RST_EDGES)
        b_cnt_q <= b_cnt_q + 3'h1; // R08
    end
  end

  // A short reset leaves the device held until a full one arrives
  wire logic rst_complete = (a_cnt_q == RST_EDGES) & (b_cnt_q == RST_EDGES);
  assign done_evt = rst_rise & rst_complete;

  // Reset sequencer
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rst_state_q <= FPPRC_IN_RESET;
    else
    begin
      case (rst_state_q)
        FPPRC_IN_RESET:
          if (done_evt)
            rst_state_q <= FPPRC_RUN; // R08
        FPPRC_RUN:
          if (!dev_rst_n)
            rst_state_q <= FPPRC_IN_RESET;
        default:
          rst_state_q <= FPPRC_IN_RESET;
      endcase
    end
  end

  // Offset selects caught at the reset release
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      offset_q <= 2'h0;
    else if (rst_rise)
      offset_q <= {offset_sel_hi, offset_sel_lo}; // R10
  end

  // Read data registers, loaded on enabled read edges
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      porta_dout_q <= '0;
      portb_dout_q <= '0;
    end
    else
    begin
      if (porta_rd)
        porta_dout_q <= porta_sel_data;
      if (portb_rd)
        portb_dout_q <= portb_sel_data;
    end
  end

  // AHB decode
  wire logic ahb_req = hsel & hready & (htrans == HTRANS_NONSEQ | htrans == HTRANS_SEQ);
  wire logic [3:0] a_ofs = haddr[3:0];
  wire logic in_map = haddr[31:4] == 28'h0; // Upper address bits clear, so no aliasing
  wire logic [31:0] state_word = {27'h0, ~peb_q, ~pea_q, offset_q, running};
  wire logic [31:0] rd_mux =
    !in_map ? 32'h0 :
    a_ofs == OFS_STATE ? state_word :
    a_ofs == OFS_CTRL ? {31'h0, ctrl_ports_q} :
    a_ofs == OFS_ISTAT ? {29'h0, istat_q} :
    a_ofs == OFS_IMASK ? {29'h0, imask_q} : 32'h0;
  wire logic wr_ctrl = wr_pend_q & (wr_ofs_q == OFS_CTRL);
  wire logic wr_istat = wr_pend_q & (wr_ofs_q == OFS_ISTAT);
  wire logic wr_imask = wr_pend_q & (wr_ofs_q == OFS_IMASK);

  // Zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // Address phase capture; read data is ready for the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_ofs_q <= 4'h0;
      hrdata_q <= 32'h0;
    end
    else
    begin
      wr_pend_q <= ahb_req & hwrite & in_map;
      wr_ofs_q <= a_ofs;
      if (ahb_req && !hwrite)
        hrdata_q <= rd_mux;
    end
  end

  // Control and mask registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_ports_q <= CTRL_RST;
      imask_q <= IMASK_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_ports_q <= hwdata[CTRL_PORTS];
      if (wr_imask)
        imask_q <= hwdata[IRQ_W-1:0];
    end
  end

  // Flag history for fall events
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pea_q <= 1'b1;
      peb_q <= 1'b1;
    end
    else
    begin
      pea_q <= porta_parity_error_n;
      peb_q <= portb_parity_error_n;
    end
  end

  // Sticky events; a new event wins over a same-cycle clear
  wire logic [IRQ_W-1:0] evt = {done_evt, peb_q & ~portb_parity_error_n,
                               pea_q & ~porta_parity_error_n};
  wire logic [IRQ_W-1:0] clr = wr_istat ? hwdata[IRQ_W-1:0] : '0;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      istat_q <= '0;
    else
      istat_q <= (istat_q & ~clr) | evt;
  end

  // Level interrupt from unmasked sticky bits
  assign irq = |(istat_q & imask_q);

  // Checks
  a_flag_defaults: assert property (@(posedge hclk) disable iff (!hresetn) // R09
    !running |-> almost_full_n && mail1_full_n && mail2_full_n && !empty_n && !full_n && !almost_empty_n)
    else $error("flags not at reset defaults");
  a_portb_parity_error_n_forced: assert property (@(posedge hclk) disable iff (!hresetn) // R04
    b_m1_gen |-> portb_parity_error_n)
    else $error("port B error flag not forced high");
  a_portb_parity_error_n_fail: assert property (@(posedge hclk) disable iff (!hresetn) // R01
    (!b_m1_gen && (^portb_din[8:0] != odd_even)) |-> !portb_parity_error_n)
    else $error("port B bad byte not flagged");
  a_porta_parity_error_n_fail: assert property (@(posedge hclk) disable iff (!hresetn) // R16
    (!a_m2_gen && (^porta_din[8:0] != odd_even)) |-> !porta_parity_error_n)
    else $error("port A bad byte not flagged");
  a_a_hiz: assert property (@(posedge hclk) disable iff (!hresetn) // R12
    porta_dir |-> !porta_oe)
    else $error("port A driven while writing");
  a_b_hiz: assert property (@(posedge hclk) disable iff (!hresetn) // R14
    portb_dir |-> !portb_oe)
    else $error("port B driven while writing");
  a_b_rd_data: assert property (@(posedge hclk) disable iff (!hresetn) // R13
    portb_rd && !portb_mailbox_sel ##1 !portb_parity_gen_en |-> portb_dout == $past(fifo_rdata))
    else $error("port B read data wrong");
  a_offset_latch: assert property (@(posedge hclk) disable iff (!hresetn) // R10
    rst_rise |=> flag_offset_sel == $past({offset_sel_hi, offset_sel_lo}))
    else $error("offset selects not latched");
  a_a_strobe: assert property (@(posedge hclk) disable iff (!hresetn) // R11
    porta_wr |-> porta_dir && a_rise && porta_en && !porta_select_n)
    else $error("port A write without enabled edge");
  a_b_gen_bit: assert property (@(posedge hclk) disable iff (!hresetn) // R06
    portb_parity_gen_en |-> ^portb_dout[8:0] == odd_even)
    else $error("port B generated parity wrong");
  a_irq_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    evt[IRQ_PEB] |=> istat_q[IRQ_PEB])
    else $error("port B error event lost");
  c_reset_done: cover property (@(posedge hclk) disable iff (!hresetn) done_evt);
  c_mail1_gen: cover property (@(posedge hclk) disable iff (!hresetn) portb_rd && b_m1_gen);
  c_a_write: cover property (@(posedge hclk) disable iff (!hresetn) porta_wr);
  c_irq: cover property (@(posedge hclk) disable iff (!hresetn) irq);
endmodule
`default_nettype wire

// ==== inc/fpprc_pkg.sv ====
// Constants, register map and parity helpers for the port parity/reset slice.
// Assumes one 200 MHz clock and a single AHB-Lite master with word accesses.
// Operation
// R01 - Port B error low on any bad byte
// R02 - Four 9-bit bytes, top bit parity
// R03 - Polarity pin picks odd or even check
// R04 - Mail1 generation read forces port B flag high
// R05 - Port A mail2 reads get generated parity
// R06 - Port B reads get generated parity
// R07 - Generation uses same polarity pin
// R08 - Reset needs four edges per port clock
// R09 - Reset sets flag defaults
// R10 - Reset release latches offset selects
// R11 - Port A direction picks write or read
// R12 - Port A outputs off while direction high
// R13 - Port B direction picks write or read
// R14 - Port B outputs off while direction high
// R15 - High polarity means odd parity
// R16 - Port A error flag, forced during mail2 generation
// R17 - Port enable must be high to transfer
// R18 - Error flags are combinational
package fpprc_pkg;
  // Port word layout
  localparam int WORD_W = 36;
  localparam int BYTE_W = 9;
  localparam int NBYTES = 4;
  localparam int PAR_BIT = 8;
  // Edges of each port clock needed inside a reset
  localparam logic [2:0] RST_EDGES = 3'h4;
  // Register byte offsets
  localparam logic [3:0] OFS_STATE = 4'h0;
  localparam logic [3:0] OFS_CTRL = 4'h4;
  localparam logic [3:0] OFS_ISTAT = 4'h8;
  localparam logic [3:0] OFS_IMASK = 4'hC;
  // Field positions
  localparam int ST_DONE = 0;
  localparam int ST_OFS_LO = 1;
  localparam int ST_PEA = 3;
  localparam int ST_PEB = 4;
  localparam int CTRL_PORTS = 0;
  localparam int IRQ_PEA = 0;
  localparam int IRQ_PEB = 1;
  localparam int IRQ_RST = 2;
  localparam int IRQ_W = 3;
  // Reset values
  localparam logic CTRL_RST = 1'h1;
  localparam logic [IRQ_W-1:0] IMASK_RST = 3'h0;
  // AHB transfer types
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  // Device reset sequencer states
  typedef enum logic [1:0] {FPPRC_IN_RESET, FPPRC_RUN} fpprc_rst_t;

  // Parity bit that makes a byte's data match the polarity (odd when high)
  function automatic logic fpprc_gen_bit(input logic [BYTE_W-2:0] d, input logic odd);
    fpprc_gen_bit = (^d) ^ odd;
  endfunction
endpackage

// ==== logic/fpprc_parity_tree.sv ====
// Shared parity tree: checks a 36-bit port word and builds its parity-filled copy.
// Assumes the polarity input is a level sampled with the port data.
`timescale 1ns/1ps
`default_nettype none
module fpprc_parity_tree
  import fpprc_pkg::*;
(
  // Word and polarity
  input wire logic [WORD_W-1:0] data,
  input wire logic odd,
  // Results
  output logic fail_any,
  output logic [WORD_W-1:0] gen_word
);
  logic [NBYTES-1:0] fail; // Per-byte check failure

  // One tree per byte; the top bit of each byte is its parity
  for (genvar i = 0; i < NBYTES; i++)
  begin : g_byte
    wire logic [BYTE_W-1:0] b = data[i*BYTE_W +: BYTE_W]; // R02
    // Odd check passes when the nine bits hold an odd count of ones
    assign fail[i] = (^b) != odd; // R03 R15
    assign gen_word[i*BYTE_W +: PAR_BIT] = b[PAR_BIT-1:0];
    assign gen_word[i*BYTE_W+PAR_BIT] = fpprc_gen_bit(b[PAR_BIT-1:0], odd); // R07
  end

  assign fail_any = |fail;
endmodule
`default_nettype wire

// ==== verif/fpprc_port_clk_model.sv ====
// Far-side model: the port master's clock for one port of the slice.
// Assumes the slice samples the port clock as a level on hclk.
`timescale 1ns/1ps
`default_nettype none
module fpprc_port_clk_model
(
  // System clock
  input wire logic hclk,
  // Burst request from the bench
  input wire logic run,
  // Port clock pin
  output var logic pclk
);
  // Starts low so the first burst edge is a clean rise
  initial pclk = 1'b0;

  // Low one hclk, high the next; stands low between bursts so no stray rise is counted
  always @(posedge hclk)
  begin
    pclk <= run ? ~pclk : 1'b0;
  end
endmodule
`default_nettype wire

// ==== verif/fpprc_port_ctrl_tb_top.sv ====
// Self-checking bench for the port parity, reset and direction slice.
// Assumes zero-wait AHB-Lite slave and port clocks sampled as levels on hclk.
`timescale 1ns/1ps
`default_nettype none
module fpprc_port_ctrl_tb_top
  import fpprc_pkg::*;
;
  // Bus side
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp, irq;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  // Shared device pins
  logic dev_rst_n = 1'b0, odd_even = 1'b0, offset_sel_lo = 1'b0, offset_sel_hi = 1'b1, run = 1'b0;
  // Port pins; data wires resolve the device drive against the bench drive
  logic porta_clk, porta_select_n = 1'b1, porta_en = 1'b0, porta_dir = 1'b1, porta_mailbox_sel = 1'b0;
  logic portb_clk, portb_select_n = 1'b1, portb_en = 1'b0, portb_dir = 1'b1, portb_mailbox_sel = 1'b0;
  logic porta_parity_gen_en = 1'b0, portb_parity_gen_en = 1'b0, porta_oe, portb_oe;
  logic porta_parity_error_n, portb_parity_error_n;
  logic [WORD_W-1:0] pa_drv = 36'h0, pb_drv = 36'h0, porta_din, portb_din, porta_dout, portb_dout;
  // Core side; flag inputs start opposite to the reset defaults
  logic almost_full_in_n = 1'b0, almost_empty_in_n = 1'b1, empty_in_n = 1'b1, full_in_n = 1'b1;
  logic mail1_full_in_n = 1'b0, mail2_full_in_n = 1'b0;
  logic [WORD_W-1:0] fifo_rdata = 36'h0, mail1_rdata = 36'h800000003, mail2_rdata = 36'h800000003;
  logic porta_wr, porta_rd, portb_wr, portb_rd, dev_in_reset;
  logic almost_full_n, almost_empty_n, empty_n, full_n, mail1_full_n, mail2_full_n;
  logic [1:0] flag_offset_sel;
  // Tallies
  int n_errors = 0, checks = 0, n_awr = 0, n_ard = 0, n_bwr = 0, n_brd = 0;
  // Parity table rows: {polarity, expected error_n, word}
  localparam logic [37:0] ROWS [6] = '{{2'h1, 36'h000000000}, {2'h2, 36'h000000000},
    {2'h3, 36'h804020100}, {2'h0, 36'h804020100}, {2'h2, 36'h004020100}, {2'h1, 36'h000000003}};

  // 200 MHz clock
  always #2.5 hclk = ~hclk;
  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;
  // Wire level: the device wins while its enable is high
  assign porta_din = porta_oe ? porta_dout : pa_drv;
  assign portb_din = portb_oe ? portb_dout : pb_drv;

  fpprc_port_clk_model u_porta_clk (.hclk, .run, .pclk(porta_clk));
  fpprc_port_clk_model u_portb_clk (.hclk, .run, .pclk(portb_clk));

  fpprc_port_ctrl DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .irq, .dev_rst_n, .odd_even, .offset_sel_lo, .offset_sel_hi,
    .porta_clk, .porta_select_n, .porta_en, .porta_dir, .porta_mailbox_sel, .porta_parity_gen_en,
    .porta_din, .porta_dout, .porta_oe, .porta_parity_error_n, .portb_clk, .portb_select_n, .portb_en,
    .portb_dir, .portb_mailbox_sel, .portb_parity_gen_en, .portb_din, .portb_dout, .portb_oe,
    .portb_parity_error_n, .almost_full_in_n, .almost_empty_in_n, .empty_in_n, .full_in_n,
    .mail1_full_in_n, .mail2_full_in_n, .fifo_rdata, .mail1_rdata, .mail2_rdata, .porta_wr, .porta_rd,
    .portb_wr, .portb_rd, .flag_offset_sel, .dev_in_reset, .almost_full_n, .almost_empty_n, .empty_n,
    .full_n, .mail1_full_n, .mail2_full_n);

  // Strobes tallied mid-cycle, away from the edge where the bench clears them
  always @(negedge hclk)
  begin
    n_awr += int'(porta_wr);
    n_ard += int'(porta_rd);
    n_bwr += int'(portb_wr);
    n_brd += int'(portb_rd);
  end

  task automatic end_sim;
    $display("checks %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Bounded wait for ready at a rising edge
  task automatic wait_ready;
    int i;
    i = 0;
    do
    begin
      @(posedge hclk);
      i++;
    end
    while (hreadyout !== 1'b1 && i < 50);
    if (hreadyout !== 1'b1)
    begin
      n_errors++;
      $display("Error at %0t: bus never ready", $time);
      end_sim();
    end
  endtask

  // One single word transfer; entered and left at a rising edge
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    check({4'h0, r}, {4'h0, e});
  endtask

  // Exactly n port clock rises on both ports, then the clocks stand low
  task automatic pulse(input int n);
    n_awr = 0;
    n_ard = 0;
    n_bwr = 0;
    n_brd = 0;
    run <= 1'b1;
    repeat (2 * n) @(posedge hclk);
    run <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    $display("Error at %0t: run timed out", $time);
    end_sim();
  end

  // Main sequence
  initial
  begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    check({29'h0, dev_in_reset, almost_full_n, mail1_full_n, mail2_full_n, empty_n, almost_empty_n, full_n}, 36'h78);
    // Three edges only: device must stay in reset
    @(posedge hclk);
    pulse(3);
    dev_rst_n <= 1'b1;
    repeat (3) @(posedge hclk);
    dev_rst_n <= 1'b0;
    check({35'h0, dev_in_reset}, 36'h1);
    pulse(4);
    dev_rst_n <= 1'b1;
    repeat (2) @(posedge hclk);
    offset_sel_lo <= 1'b1;
    offset_sel_hi <= 1'b0;
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    check({33'h0, dev_in_reset, flag_offset_sel}, 36'h2);
    check({30'h0, almost_full_n, mail1_full_n, mail2_full_n, empty_n, almost_empty_n, full_n}, 36'h7);
    $display("reset test done");
    // Parity table, both ports in write direction so the bench owns the wires
    foreach (ROWS[k])
    begin
      @(posedge hclk);
      odd_even <= ROWS[k][37];
      pa_drv <= ROWS[k][35:0];
      pb_drv <= ROWS[k][35:0];
      @(negedge hclk);
      check({34'h0, porta_parity_error_n, portb_parity_error_n}, {34'h0, {2{ROWS[k][36]}}});
    end
    $display("parity table done");
    // Registers and interrupt
    @(posedge hclk);
    rd_chk({28'h0, OFS_IMASK}, 32'h0);
    rd_chk({28'h0, OFS_CTRL}, 32'h1);
    rd_chk({28'h0, OFS_ISTAT}, 32'h7);
    check({35'h0, irq}, 36'h0);
    wr({28'h0, OFS_IMASK}, 32'h4);
    @(negedge hclk);
    check({35'h0, irq}, 36'h1);
    @(posedge hclk);
    wr({28'h0, OFS_ISTAT}, 32'h7);
    @(negedge hclk);
    check({35'h0, irq}, 36'h0);
    @(posedge hclk);
    rd_chk({28'h0, OFS_ISTAT}, 32'h0);
    rd_chk(32'h10, 32'h0);
    rd_chk({28'h0, OFS_STATE}, 32'h5);
    $display("register test done");
    // Port transfers refused while the port enable bit is clear
    wr({28'h0, OFS_CTRL}, 32'h0);
    porta_select_n <= 1'b0;
    portb_select_n <= 1'b0;
    porta_en <= 1'b1;
    portb_en <= 1'b1;
    pulse(2);
    check({20'h0, n_awr[3:0], n_ard[3:0], n_bwr[3:0], n_brd[3:0]}, 36'h0);
    wr({28'h0, OFS_CTRL}, 32'h1);
    pulse(2);
    check({20'h0, n_awr[3:0], n_ard[3:0], n_bwr[3:0], n_brd[3:0]}, 36'h2020);
    // Mailbox reads with parity generation
    porta_dir <= 1'b0;
    portb_dir <= 1'b0;
    porta_mailbox_sel <= 1'b1;
    portb_mailbox_sel <= 1'b1;
    porta_parity_gen_en <= 1'b1;
    portb_parity_gen_en <= 1'b1;
    odd_even <= 1'b1;
    pulse(1);
    @(negedge hclk);
    check({20'h0, n_awr[3:0], n_ard[3:0], n_bwr[3:0], n_brd[3:0]}, 36'h0101);
    check(porta_dout, 36'h804020103);
    check(portb_dout, 36'h804020103);
    check({32'h0, porta_parity_error_n, portb_parity_error_n, porta_oe, portb_oe}, 36'hF);
    @(posedge hclk);
    odd_even <= 1'b0;
    @(negedge hclk);
    check(porta_dout, 36'h000000003);
    check(portb_dout, 36'h000000003);
    @(posedge hclk);
    porta_parity_gen_en <= 1'b0;
    portb_parity_gen_en <= 1'b0;
    @(negedge hclk);
    check(porta_dout, 36'h800000003);
    check(portb_dout, 36'h800000003);
    // Port B FIFO read, mailbox deselected, no generation
    @(posedge hclk);
    portb_mailbox_sel <= 1'b0;
    fifo_rdata <= 36'h0000000FF;
    pulse(1);
    @(negedge hclk);
    check(portb_dout, 36'h0000000FF);
    @(posedge hclk);
    porta_dir <= 1'b1;
    portb_dir <= 1'b1;
    @(negedge hclk);
    check({34'h0, porta_oe, portb_oe}, 36'h0);
    $display("port test done");
    end_sim();
  end
endmodule
`default_nettype wire
